// ---- rtl/mc_regs_pkg.sv ----
// Constants and types for the machine-check register set.
// Assumes one 10 MHz clock and register ops issued by the core on that clock.
package mc_regs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Sizes
  localparam int NUM_BANKS = 4;
  localparam logic [63:0] IMPL_MASK = 64'h0000_0000_0000_FFFF;

  ////////////////////////////////////////////////////////////////////////////
  // Addresses
  localparam logic [31:0] CAP_ADDR = 32'h0000_0179;
  localparam logic [31:0] GSTAT_ADDR = 32'h0000_017A;
  localparam logic [31:0] GEN_ADDR = 32'h0000_017B;
  localparam logic [31:0] BANK_BASE = 32'h0000_0400;
  localparam logic [31:0] BANK_SPAN = 32'h0000_0010;
  localparam logic [1:0] SUB_CTL = 2'h0;
  localparam logic [1:0] SUB_STAT = 2'h1;

  ////////////////////////////////////////////////////////////////////////////
  // Capability contents
  localparam logic [7:0] CAP_COUNT = 8'(NUM_BANKS);
  localparam logic GEN_PRESENT = 1'h1;
  localparam logic EXT_PRESENT = 1'h0;
  localparam logic CMCI_PRESENT = 1'h0;
  localparam logic TES_PRESENT = 1'h1;
  localparam logic [7:0] EXT_REG_COUNT = 8'h00;
  localparam logic SER_PRESENT = 1'h0;
  localparam logic [63:0] CAP_VALUE = {39'h0, SER_PRESENT, EXT_REG_COUNT, 4'h0,
    TES_PRESENT, CMCI_PRESENT, EXT_PRESENT, GEN_PRESENT, CAP_COUNT};

  ////////////////////////////////////////////////////////////////////////////
  // Field positions and reset values
  localparam int GS_RESTART_POINT_GOOD = 0;
  localparam int GS_FAULT_POINT_GOOD = 1;
  localparam int GS_CHECK_HANDLER_ACTIVE = 2;
  localparam int ST_VAL = 63;
  localparam int ST_OVER = 62;
  localparam int ST_UC = 61;
  localparam int ST_EN = 60;
  localparam int ST_THR_MSB = 54;
  localparam int ST_THR_LSB = 53;
  localparam int ST_MODEL_MSB = 31;
  localparam int ST_MODEL_LSB = 16;
  localparam int ST_MCA_MSB = 15;
  localparam logic [1:0] THR_YELLOW = 2'h2;
  localparam logic [63:0] CTL_RST = 64'h0000_0000_0000_0000;
  localparam logic [63:0] GEN_RST = 64'h0000_0000_0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // State types
  typedef struct packed {
    logic [63:0] ctl;
    logic [63:0] stat;
  } bank_state_t;

  typedef struct packed {
    logic [2:0] gstat;
    logic [63:0] gen;
    logic [63:0] rdata;
    logic ack;
    logic gp;
    logic exc;
    logic shutdown;
  } main_state_t;

endpackage

// ---- rtl/error_bank.sv ----
// One error-reporting bank: enable flags and the error record.
// Assumes the parent decodes writes and feeds errors on the same clock.
`timescale 1ns/1ns
`default_nettype none
module error_bank (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ctl_wr,
  input wire logic i_stat_clr,
  input wire logic [63:0] i_wdata,
  input wire logic i_err,
  input wire logic [5:0] i_err_idx,
  input wire logic i_err_uc,
  input wire logic [1:0] i_err_color,
  input wire logic [15:0] i_err_mca,
  input wire logic [15:0] i_err_model,
  output logic [63:0] o_ctl,
  output logic [63:0] o_stat,
  output logic o_raise
);
  import mc_regs_pkg::*;

  bank_state_t s_q;
  bank_state_t s_d;
  logic [63:0] rec;
  logic old_val;
  logic new_wins;

  ////////////////////////////////////////////////////////////////////////////
  // Next state: writes first, then a new error on top
  always_comb begin
    s_d = s_q;
    if (i_ctl_wr) begin
      s_d.ctl = (s_q.ctl & ~IMPL_MASK) | (i_wdata & IMPL_MASK);
    end
    if (i_stat_clr) begin
      s_d.stat = '0;
    end
    old_val = s_d.stat[ST_VAL];
    // Uncorrected kept over all; yellow kept over green
    new_wins = !old_val || (!s_d.stat[ST_UC] && (i_err_uc ||
      !(s_d.stat[ST_THR_MSB:ST_THR_LSB] == THR_YELLOW && i_err_color != THR_YELLOW)));
    // Bits 59:55 and 52:32 stay zero here
    rec = '0;
    rec[ST_VAL] = 1'b1;
    rec[ST_UC] = i_err_uc;
    rec[ST_EN] = s_q.ctl[i_err_idx];
    if (!i_err_uc) begin
      rec[ST_THR_MSB:ST_THR_LSB] = i_err_color;
    end
    rec[ST_MODEL_MSB:ST_MODEL_LSB] = i_err_model;
    rec[ST_MCA_MSB:0] = i_err_mca;
    if (i_err) begin
      if (new_wins) begin
        s_d.stat = rec;
      end
      if (old_val) begin
        s_d.stat[ST_OVER] = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q <= '{ctl: CTL_RST, stat: 64'h0};
    end else begin
      s_q <= s_d;
    end
  end

  // Uncorrected enabled error asks for the exception
  assign o_raise = i_err && s_q.ctl[i_err_idx] && i_err_uc;
  assign o_ctl = s_q.ctl;
  assign o_stat = s_q.stat;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  a_record_sets_val: assert property (i_err |=> s_q.stat[ST_VAL])
    else $error("record did not set present flag");
  a_second_sets_over: assert property (i_err && s_q.stat[ST_VAL] && !i_stat_clr
    |=> s_q.stat[ST_OVER])
    else $error("second error did not set overflow");
  a_unimpl_ctl_zero: assert property ((s_q.ctl & ~IMPL_MASK) == 64'h0)
    else $error("unimplemented enable bit changed");

endmodule // error_bank
`default_nettype wire

// ---- rtl/machine_check_regs.sv ----
// Machine-check register set: capability, global state, global enable, banks.
// Assumes register ops and error reports come from core logic on i_clk.
`timescale 1ns/1ns
`default_nettype none
module machine_check_regs (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_op_rd,
  input wire logic i_op_wr,
  input wire logic [31:0] i_op_addr,
  input wire logic [63:0] i_op_wdata,
  input wire logic i_err_valid,
  input wire logic [7:0] i_err_bank,
  input wire logic [5:0] i_err_idx,
  input wire logic i_err_uc,
  input wire logic [1:0] i_err_color,
  input wire logic [15:0] i_err_mca,
  input wire logic [15:0] i_err_model,
  input wire logic i_restart_ok,
  input wire logic i_ip_tied,
  output logic o_op_ack,
  output logic [63:0] o_op_rdata,
  output logic o_op_gp,
  output logic o_fault_exc,
  output logic o_shutdown
);
  import mc_regs_pkg::*;

  main_state_t s_q;
  main_state_t s_d;
  logic [31:0] off;
  logic [7:0] bidx;
  logic [1:0] sub;
  logic hit_cap;
  logic hit_gstat;
  logic hit_gen;
  logic hit_bank;
  logic raise_any;
  logic [NUM_BANKS-1:0] raise_v;
  logic [63:0] ctl_a [NUM_BANKS];
  logic [63:0] stat_a [NUM_BANKS];

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  assign off = i_op_addr - BANK_BASE;
  assign bidx = off[9:2];
  assign sub = off[1:0];
  assign hit_cap = (i_op_addr == CAP_ADDR);
  assign hit_gstat = (i_op_addr == GSTAT_ADDR);
  assign hit_gen = (i_op_addr == GEN_ADDR);
  assign hit_bank = (i_op_addr >= BANK_BASE) && (off < BANK_SPAN);

  ////////////////////////////////////////////////////////////////////////////
  // Error-reporting banks
  generate
    for (genvar g = 0; g < NUM_BANKS; g++) begin : g_bank
      logic ctl_wr;
      logic stat_clr;
      logic err;
      assign ctl_wr = i_op_wr && hit_bank && bidx == 8'(g) && sub == SUB_CTL;
      // Only an all-zero write clears the record
      assign stat_clr = i_op_wr && hit_bank && bidx == 8'(g) && sub == SUB_STAT
        && i_op_wdata == 64'h0;
      assign err = i_err_valid && i_err_bank == 8'(g);
      error_bank u_bank (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_ctl_wr(ctl_wr),
        .i_stat_clr(stat_clr),
        .i_wdata(i_op_wdata),
        .i_err(err),
        .i_err_idx(i_err_idx),
        .i_err_uc(i_err_uc),
        .i_err_color(i_err_color),
        .i_err_mca(i_err_mca),
        .i_err_model(i_err_model),
        .o_ctl(ctl_a[g]),
        .o_stat(stat_a[g]),
        .o_raise(raise_v[g])
      );
    end
  endgenerate

  // Bank raise gated by its global enable bit
  assign raise_any = |(raise_v & s_q.gen[NUM_BANKS-1:0]);

  ////////////////////////////////////////////////////////////////////////////
  // Next state: register ops, then hardware events
  always_comb begin
    s_d = s_q;
    s_d.ack = i_op_rd || i_op_wr;
    s_d.gp = 1'b0;
    s_d.exc = 1'b0;
    // Read path
    if (i_op_rd) begin
      s_d.rdata = 64'h0;
      if (hit_cap) begin
        s_d.rdata = CAP_VALUE;
      end else if (hit_gstat) begin
        s_d.rdata = {61'h0, s_q.gstat};
      end else if (hit_gen) begin
        s_d.rdata = s_q.gen;
      end else if (hit_bank) begin
        if (sub == SUB_CTL) begin
          s_d.rdata = ctl_a[bidx[1:0]];
        end else if (sub == SUB_STAT) begin
          s_d.rdata = stat_a[bidx[1:0]];
        end
      end else begin
        s_d.gp = 1'b1;
      end
    end
    // Write path
    if (i_op_wr) begin
      if (hit_gstat) begin
        s_d.gstat = i_op_wdata[2:0];
      end else if (hit_gen) begin
        s_d.gen = i_op_wdata;
      end else if (hit_cap) begin
        s_d.gp = 1'b0; // Capability writes dropped
      end else if (hit_bank) begin
        s_d.gp = (sub == SUB_STAT) && (i_op_wdata != 64'h0);
      end else begin
        s_d.gp = 1'b1;
      end
    end
    // Machine-check event wins over a same-cycle write
    if (raise_any) begin
      if (s_q.gstat[GS_CHECK_HANDLER_ACTIVE]) begin
        s_d.shutdown = 1'b1;
      end else begin
        s_d.exc = 1'b1;
        s_d.gstat[GS_CHECK_HANDLER_ACTIVE] = 1'b1;
        s_d.gstat[GS_RESTART_POINT_GOOD] = i_restart_ok;
        s_d.gstat[GS_FAULT_POINT_GOOD] = i_ip_tied;
      end
    end
  end

  // State register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q <= '{gstat: 3'h0, gen: GEN_RST, rdata: 64'h0, ack: 1'b0, gp: 1'b0,
        exc: 1'b0, shutdown: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from state
  assign o_op_ack = s_q.ack;
  assign o_op_rdata = s_q.rdata;
  assign o_op_gp = s_q.gp;
  assign o_fault_exc = s_q.exc;
  assign o_shutdown = s_q.shutdown;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  a_cap_read_value: assert property (i_op_rd && hit_cap
    |=> o_op_ack && o_op_rdata[7:0] == 8'(NUM_BANKS) && o_op_rdata[8])
    else $error("capability read wrong");
  // All records checked, as the address may move on in the next cycle
  a_ones_write_gp: assert property (i_op_wr && hit_bank && sub == SUB_STAT
    && i_op_wdata != 64'h0 && !i_err_valid
    |=> o_op_gp && $stable({stat_a[0], stat_a[1], stat_a[2], stat_a[3]}))
    else $error("nonzero status write not faulted");
  a_nested_shutdown: assert property (raise_any && s_q.gstat[GS_CHECK_HANDLER_ACTIVE]
    |=> o_shutdown && !o_fault_exc)
    else $error("nested event did not shut down");
  a_exc_sets_active: assert property (o_fault_exc |-> s_q.gstat[GS_CHECK_HANDLER_ACTIVE]
    ##1 (s_q.gstat[GS_CHECK_HANDLER_ACTIVE] || $past(i_op_wr)))
    else $error("exception without active flag");
  a_global_gating: assert property (s_q.gen == 64'h0 |=> !o_fault_exc)
    else $error("exception while globally disabled");
  a_gstat_reserved: assert property (i_op_rd && hit_gstat
    |=> o_op_rdata[63:3] == 61'h0)
    else $error("reserved global bits not zero");
  a_restart_capture: assert property (raise_any && !s_q.gstat[GS_CHECK_HANDLER_ACTIVE]
    |=> s_q.gstat[GS_RESTART_POINT_GOOD] == $past(i_restart_ok)
    && s_q.gstat[GS_FAULT_POINT_GOOD] == $past(i_ip_tied))
    else $error("restart flags not captured");
  a_shutdown_sticky: assert property (o_shutdown |=> o_shutdown)
    else $error("shutdown released");

  c_exception: cover property (o_fault_exc);
  c_shutdown: cover property (!o_shutdown ##1 o_shutdown);
  c_status_fault: cover property (o_op_gp && o_op_ack);
  c_overflow: cover property (i_err_valid && stat_a[i_err_bank[1:0]][ST_VAL]);

endmodule // machine_check_regs
`default_nettype wire

// ---- tb/test_machine_check_regs.sv ----
// Self-checking bench for the machine-check register set.
// Assumes the design carries its own assertions; inputs change on the falling edge.
`timescale 1ns/1ns
`default_nettype none
module test_machine_check_regs;
  import mc_regs_pkg::*;

  logic i_clk, i_rst_n, i_op_rd, i_op_wr, i_err_valid, i_err_uc, i_restart_ok, i_ip_tied;
  logic [31:0] i_op_addr;
  logic [63:0] i_op_wdata, o_op_rdata, rd, s, cap_exp;
  logic [7:0] i_err_bank;
  logic [5:0] i_err_idx;
  logic [1:0] i_err_color;
  logic [15:0] i_err_mca, i_err_model;
  logic o_op_ack, o_op_gp, o_fault_exc, o_shutdown, gp, ex, sd;
  int error_cnt = 0;
  int n_tests = 0;
  int seed;

  machine_check_regs machine_check_regs_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_op_rd(i_op_rd), .i_op_wr(i_op_wr), .i_op_addr(i_op_addr), .i_op_wdata(i_op_wdata),
    .i_err_valid(i_err_valid), .i_err_bank(i_err_bank), .i_err_idx(i_err_idx),
    .i_err_uc(i_err_uc), .i_err_color(i_err_color), .i_err_mca(i_err_mca),
    .i_err_model(i_err_model), .i_restart_ok(i_restart_ok), .i_ip_tied(i_ip_tied),
    .o_op_ack(o_op_ack), .o_op_rdata(o_op_rdata), .o_op_gp(o_op_gp),
    .o_fault_exc(o_fault_exc), .o_shutdown(o_shutdown));

  ////////////////////////////////////////////////////////////////////////////
  // Clock, 100 ns period
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checking, verdict and expectations
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string msg);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("Comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Expected record: present, overflow, uncorrected, enabled, color, codes
  function automatic logic [63:0] st(input logic ov, input logic uc, input logic en,
    input logic [1:0] c, input logic [15:0] mo, input logic [15:0] mc);
    st = {1'b1, ov, uc, en, 5'h0, c, 21'h0, mo, mc};
  endfunction

  function automatic logic [31:0] ba(input int b, input int sub);
    ba = BANK_BASE + 32'(4 * b + sub);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Drivers: one-cycle request, answer sampled one cycle later
  task automatic op(input logic wr, input logic [31:0] a, input logic [63:0] wd);
    @(negedge i_clk);
    i_op_rd = ~wr;
    i_op_wr = wr;
    i_op_addr = a;
    i_op_wdata = wd;
    @(negedge i_clk);
    i_op_rd = 1'b0;
    i_op_wr = 1'b0;
    rd = o_op_rdata;
    gp = o_op_gp;
    if (o_op_ack !== 1'b1) begin
      chk(o_op_ack, 1'b1, "no acknowledge");
      complete_run();
    end
  endtask

  // Error report with random codes; exception and shutdown sampled next cycle
  task automatic err(input logic [7:0] b, input logic [5:0] x, input logic uc,
    input logic [1:0] c);
    @(negedge i_clk);
    i_err_valid = 1'b1;
    i_err_bank = b;
    i_err_idx = x;
    i_err_uc = uc;
    i_err_color = c;
    i_err_mca = 16'($urandom);
    i_err_model = 16'($urandom);
    i_restart_ok = 1'($urandom);
    i_ip_tied = 1'($urandom);
    @(negedge i_clk);
    i_err_valid = 1'b0;
    ex = o_fault_exc;
    sd = o_shutdown;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    seed = $urandom(59339);
    {i_rst_n, i_op_rd, i_op_wr, i_err_valid, i_err_uc, i_restart_ok, i_ip_tied} = 7'h00;
    {i_op_addr, i_op_wdata, i_err_bank, i_err_idx, i_err_color} = '0;
    {i_err_mca, i_err_model} = 32'h0000_0000;
    repeat (5) @(negedge i_clk);
    i_rst_n = 1'b1;
    cap_exp = 64'h0000_0000_0000_0900 | 64'(NUM_BANKS);
    op(1'b0, CAP_ADDR, '0);
    chk(rd, cap_exp, "capability");
    op(1'b1, CAP_ADDR, '1);
    chk(gp, 1'b0, "capability write fault");
    op(1'b0, CAP_ADDR, '0);
    chk(rd, cap_exp, "capability after write");
    $display("test capability done");
    op(1'b0, GSTAT_ADDR, '0);
    chk(rd, 64'h0, "global state reset");
    op(1'b1, GSTAT_ADDR, '1);
    op(1'b0, GSTAT_ADDR, '0);
    chk(rd, 64'h7, "global state write");
    op(1'b1, GSTAT_ADDR, '0);
    op(1'b1, GEN_ADDR, '1);
    op(1'b0, GEN_ADDR, '0);
    chk(rd, '1, "global enable");
    $display("test global done");
    for (int b = 0; b < NUM_BANKS; b++) begin
      s = {32'($urandom), 32'($urandom)};
      op(1'b1, ba(b, 0), s);
      op(1'b0, ba(b, 0), '0);
      chk(rd, s & IMPL_MASK, "bank enables");
      op(1'b0, ba(b, 1), '0);
      chk(rd, 64'h0, "bank record reset");
    end
    op(1'b1, ba(0, 1), 64'h1);
    chk(gp, 1'b1, "record write ones");
    op(1'b1, ba(0, 1), '0);
    chk(gp, 1'b0, "record write zeros");
    op(1'b0, 32'h0000_0300, '0);
    chk(gp, 1'b1, "unmapped read fault");
    chk(rd, 64'h0, "unmapped read data");
    $display("test banks done");
    op(1'b1, ba(0, 0), 64'h8);
    err(8'h00, 6'h03, 1'b1, 2'h0);
    chk(ex, 1'b1, "exception raised");
    s = st(1'b0, 1'b1, 1'b1, 2'h0, i_err_model, i_err_mca);
    op(1'b0, GSTAT_ADDR, '0);
    chk(rd, {61'h0, 1'b1, i_ip_tied, i_restart_ok}, "global state");
    op(1'b0, ba(0, 1), '0);
    chk(rd, s, "record");
    err(8'h00, 6'h03, 1'b0, 2'h2);
    chk(ex, 1'b0, "corrected no exception");
    op(1'b0, ba(0, 1), '0);
    chk(rd, s | 64'h4000_0000_0000_0000, "overflow keeps uncorrected");
    op(1'b1, GSTAT_ADDR, '0);
    op(1'b1, ba(1, 0), '0);
    err(8'h01, 6'h03, 1'b1, 2'h0);
    chk(ex, 1'b0, "disabled no exception");
    op(1'b0, ba(1, 1), '0);
    chk(rd, st(1'b0, 1'b1, 1'b0, 2'h0, i_err_model, i_err_mca), "disabled record");
    op(1'b1, GEN_ADDR, '0);
    op(1'b1, ba(2, 0), '1); // All-ones enable write
    err(8'h02, 6'h05, 1'b1, 2'h0);
    chk(ex, 1'b0, "globally disabled");
    $display("test errors done");
    op(1'b1, ba(2, 1), '0);
    op(1'b1, GEN_ADDR, '1);
    err(8'h02, 6'h05, 1'b1, 2'h0);
    chk({ex, sd}, 2'b10, "first exception");
    err(8'h02, 6'h05, 1'b1, 2'h0);
    chk({ex, sd}, 2'b01, "nested event shutdown");
    repeat (3) @(negedge i_clk);
    chk(o_shutdown, 1'b1, "shutdown sticky");
    $display("test shutdown done");
    // Mid-run reset clears shutdown, enables and records
    i_rst_n = 1'b0;
    repeat (2) @(negedge i_clk);
    chk(o_shutdown, 1'b0, "shutdown cleared by reset");
    i_rst_n = 1'b1;
    op(1'b0, GEN_ADDR, '0);
    chk(rd, 64'h0, "global enable after reset");
    op(1'b0, ba(2, 1), '0);
    chk(rd, 64'h0, "record after reset");
    // Corrected errors: yellow kept over a later green
    err(8'h03, 6'h00, 1'b0, 2'h2);
    s = st(1'b0, 1'b0, 1'b0, 2'h2, i_err_model, i_err_mca);
    op(1'b0, ba(3, 1), '0);
    chk(rd, s, "yellow record");
    err(8'h03, 6'h00, 1'b0, 2'h1);
    chk(ex, 1'b0, "green no exception");
    op(1'b0, ba(3, 1), '0);
    chk(rd, s | 64'h4000_0000_0000_0000, "yellow kept over green");
    $display("test reset and color done");
    complete_run();
  end
endmodule // test_machine_check_regs
`default_nettype wire
